/* File: rsq_pkg.sv */
// Purpose: Shared constants and types of the reset sequencer.
// Assumes: 200 MHz mclk; 8-bit register port.
// Notes: Fuse bit positions and register offsets are fixed here.
package rsq_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned DRT_TIME_MS = 72;
    localparam int unsigned DRT_CYCLES_DEF = DRT_TIME_MS * 1000 * CLK_MHZ;
    localparam int DRT_W = 10;
    localparam int unsigned DRT_STEPS = 1024;
    localparam logic [DRT_W-1:0] DRT_TERM = 10'h3ff;

    // ************************************************************
    // Register port
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CAUSE = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_SOURCES = 4'h3;

    // Event bits of status and mask
    localparam int EV_W = 6;
    localparam int EV_POR = 0;
    localparam int EV_BOR = 1;
    localparam int EV_WDT = 2;
    localparam int EV_EXT = 3;
    localparam int EV_WAKE = 4;
    localparam int EV_RELEASE = 5;
    localparam logic [EV_W-1:0] EV_RESET_VAL = 6'h01;
    localparam logic [EV_W-1:0] MASK_RESET_VAL = 6'h00;

    // ************************************************************
    // Fuses
    // ************************************************************
    localparam int FUSE_W = 12;
    localparam int FUSE_BOR_LO_BIT = 6;
    localparam int FUSE_BOR_HI_BIT = 7;
    localparam logic [1:0] BOR_CFG_OFF = 2'h3;

    // ************************************************************
    // Register reset values
    // ************************************************************
    localparam int PC_W = 11;
    localparam logic [PC_W-1:0] PC_TOP = 11'h7ff;
    localparam logic [7:0] ALL_ONES_RST = 8'hff;
    localparam logic [7:0] MODE_RST = 8'h0f;
    localparam logic [7:0] PCL_RST = 8'hff;
    localparam logic [7:0] CMP_RST = 8'hc1;
    localparam logic [2:0] STATUS_HI_RST = 3'h0;
    localparam logic [1:0] TPD_POWERUP = 2'h3;
    localparam logic [1:0] TPD_WDT_PD = 2'h0;
    localparam logic [1:0] TPD_WDT_ACT = 2'h1;
    localparam logic [1:0] TPD_EXT_PD = 2'h2;
    localparam logic FSP_TOP_RST = 1'b1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        CAUSE_POR = 3'h0,
        CAUSE_BOR = 3'h1,
        CAUSE_WDT = 3'h2,
        CAUSE_EXT = 3'h3,
        CAUSE_WAKE = 3'h4
    } rsq_cause_t;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_COUNT = 2'b01,
        ST_RUN = 2'b11
    } rsq_state_t;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [7:0] pcl;
        logic [7:0] option;
        logic [7:0] mode;
        logic [7:0] port_dir;
        logic [7:0] wake_edge_sel;
        logic [7:0] wake_enable_n;
        logic [7:0] input_level_select;
        logic [7:0] schmitt_select;
        logic [7:0] pullup_enable_n;
        logic [7:0] comparator_ctrl;
        logic [2:0] status_hi;
        logic file_select_top;
    } rsq_init_t;

    typedef struct packed {
        logic load_fixed;
        logic load_fsp_top;
        logic fsp_low_undef;
        logic volatile_undef;
        logic status_low_undef;
        logic [1:0] tpd;
    } rsq_load_t;

endpackage

/* File: rsq_drt.sv */
// Purpose: Delay reset timer, a 10-bit count of prescaled ticks.
// Assumes: clear and run never high together.
// Notes: Total delay is DRT_STEPS ticks of TICK cycles each.
`timescale 1ns/100ps
module rsq_drt
    import rsq_pkg::*;
#(
    parameter int unsigned CYCLES = DRT_CYCLES_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic clear,
    input wire logic run,
    // Status
    output logic done
);
    localparam int unsigned TICK_RAW = (CYCLES + DRT_STEPS - 1) / DRT_STEPS;
    localparam int unsigned TICK = (TICK_RAW < 1) ? 1 : TICK_RAW;
    localparam int PRE_W = $clog2(TICK + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK - 1);

    logic [PRE_W-1:0] pre;
    logic [DRT_W-1:0] count;
    wire tick = run && !done && (pre == PRE_LAST);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pre <= '0;
            count <= '0;
            done <= 1'b0;
        end else if (ce) begin
            if (clear) begin
                pre <= '0;
                count <= '0;
                done <= 1'b0;
            end else if (tick) begin
                pre <= '0;
                count <= count + 1'b1;
                done <= (count == DRT_TERM); // RULE_04
            end else if (run && !done) begin
                pre <= pre + 1'b1;
            end
        end
    end
endmodule // rsq_drt

/* File: rsq_reset_seq.sv */
// Purpose: Reset sequencer and register initialiser of a small core.
// Assumes: rst is the power-on detector; pin and detector inputs are asynchronous.
// Notes: Undefined register bits are driven as zero where a value is needed.
// Overview of operation
// RULE_01 - Power-up, brown-out, watchdog and pin resets all send the program counter to the top.
// RULE_02 - A 10-bit delay timer sets the release delay and a latch drives the internal reset.
// RULE_03 - Power-up sets the latch and the timer only counts once the pin is seen high.
// RULE_04 - At the terminal count of about 72 ms the latch clears and the core is released.
// RULE_05 - Reset stays on while brown-out is indicated and ends only after it goes away.
// RULE_06 - Two fuse bits can disable the brown-out source so it never causes reset.
// RULE_07 - Every reset sets option, direction, wake, level, Schmitt and pull-up to FFh, mode 0Fh.
// RULE_08 - Working, counter, data, file, wake pending and watchdog state are undefined on power-up.
// RULE_09 - The low program counter byte becomes FFh on every reset, wakeup included.
// RULE_10 - Status bits 5 to 7 clear on every reset; power-up sets timeout and power-down to 11.
// RULE_11 - Pointer bit 7 is set on all but power-up; its low bits are lost only on brown-out. Code also marks them undefined on power-up.
// RULE_12 - Comparator control bits 0, 6 and 7 are set on every reset, disabling it.
// RULE_13 - Watchdog and pin resets set timeout and power-down by whether the core slept.
// RULE_14 - Internal reset is the latch OR any active source, synchronous to the clock.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/100ps
module rsq_reset_seq
    import rsq_pkg::*;
#(
    parameter int unsigned DRT_CYCLES = DRT_CYCLES_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Reset sources
    input wire logic ext_reset_pin_n,
    input wire logic brownout_det,
    input wire logic [FUSE_W-1:0] extended_fuse_word,
    input wire logic watchdog_timeout,
    input wire logic wakeup_event,
    input wire logic in_powerdown,
    // Core side
    output logic core_reset,
    output rsq_init_t init_val,
    output rsq_load_t init_load,
    output rsq_cause_t reset_cause,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Interrupt
    output logic irq
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic pin_meta;
    logic pin_sync;
    logic bor_meta;
    logic bor_sync;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            bor_meta <= 1'b0;
            bor_sync <= 1'b0;
        end else if (ce) begin
            pin_meta <= ext_reset_pin_n;
            pin_sync <= pin_meta;
            bor_meta <= brownout_det;
            bor_sync <= bor_meta;
        end
    end

    // ************************************************************
    // Source decode
    // ************************************************************
    wire brownout_cfg_lo = extended_fuse_word[FUSE_BOR_LO_BIT];
    wire brownout_cfg_hi = extended_fuse_word[FUSE_BOR_HI_BIT];
    wire bor_enabled = ({brownout_cfg_hi, brownout_cfg_lo} != BOR_CFG_OFF); // RULE_06
    wire bor_active = bor_sync && bor_enabled; // RULE_06
    wire ext_active = !pin_sync;

    logic bor_prev;
    logic ext_prev;

    wire bor_rise = bor_active && !bor_prev;
    wire ext_rise = ext_active && !ext_prev;
    wire any_event = bor_rise || watchdog_timeout || ext_rise || wakeup_event; // RULE_01

    // Priority: brown-out, watchdog, pin, wakeup
    wire rsq_cause_t next_cause = bor_rise ? CAUSE_BOR :
                                  watchdog_timeout ? CAUSE_WDT :
                                  ext_rise ? CAUSE_EXT : CAUSE_WAKE;

    // ************************************************************
    // Reset latch state machine
    // ************************************************************
    rsq_state_t state;
    rsq_state_t next_state;
    logic drt_done;

    wire sources_on = bor_active || ext_active;
    wire drt_clear = (state == ST_HOLD);
    wire drt_run = (state == ST_COUNT);
    wire release_evt = drt_run && drt_done && !sources_on && !any_event;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_HOLD: begin
                if (!sources_on) begin
                    next_state = ST_COUNT; // RULE_03
                end
            end
            ST_COUNT: begin
                if (sources_on || any_event) begin
                    next_state = ST_HOLD; // RULE_05
                end else if (drt_done) begin
                    next_state = ST_RUN; // RULE_04
                end
            end
            ST_RUN: begin
                if (any_event || sources_on) begin
                    next_state = ST_HOLD; // RULE_01
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    rsq_drt #(
        .CYCLES(DRT_CYCLES)
    ) u_drt (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .clear(drt_clear),
        .run(drt_run),
        .done(drt_done)
    ); // RULE_02

    // Latch set while not running
    wire reset_latch = (next_state != ST_RUN); // RULE_02
    wire next_core_reset = reset_latch || sources_on || any_event; // RULE_14

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ST_HOLD; // RULE_03
            core_reset <= 1'b1;
            bor_prev <= 1'b0;
            ext_prev <= 1'b1;
        end else if (ce) begin
            state <= next_state;
            core_reset <= next_core_reset; // RULE_14
            bor_prev <= bor_active;
            ext_prev <= ext_active;
        end
    end

    // ************************************************************
    // Timeout and power-down flags
    // ************************************************************
    logic [1:0] tpd;
    logic [1:0] next_tpd;

    always_comb begin
        next_tpd = tpd;
        if (any_event) begin
            unique case (next_cause)
                CAUSE_WDT: next_tpd = in_powerdown ? TPD_WDT_PD : TPD_WDT_ACT; // RULE_13
                CAUSE_EXT: next_tpd = in_powerdown ? TPD_EXT_PD : tpd; // RULE_13
                CAUSE_BOR: next_tpd = tpd;
                CAUSE_WAKE: next_tpd = tpd; // RULE_10
                CAUSE_POR: next_tpd = TPD_POWERUP;
            endcase
        end
    end

    // ************************************************************
    // Register initial values for the core
    // ************************************************************
    function automatic rsq_load_t load_for(input rsq_cause_t c, input logic [1:0] t);
        rsq_load_t l;
        l.load_fixed = 1'b1; // RULE_07
        l.load_fsp_top = (c != CAUSE_POR); // RULE_11
        l.fsp_low_undef = (c == CAUSE_BOR) || (c == CAUSE_POR); // RULE_11
        l.volatile_undef = (c == CAUSE_BOR) || (c == CAUSE_POR); // RULE_08
        l.status_low_undef = (c == CAUSE_BOR);
        l.tpd = t; // RULE_10
        return l;
    endfunction

    localparam rsq_load_t LOAD_POR = load_for(CAUSE_POR, TPD_POWERUP);

    localparam rsq_init_t INIT_RST = '{
        pc: PC_TOP,
        pcl: PCL_RST,
        option: ALL_ONES_RST,
        mode: MODE_RST,
        port_dir: ALL_ONES_RST,
        wake_edge_sel: ALL_ONES_RST,
        wake_enable_n: ALL_ONES_RST,
        input_level_select: ALL_ONES_RST,
        schmitt_select: ALL_ONES_RST,
        pullup_enable_n: ALL_ONES_RST,
        comparator_ctrl: CMP_RST, // RULE_12
        status_hi: STATUS_HI_RST,
        file_select_top: FSP_TOP_RST
    };

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tpd <= TPD_POWERUP; // RULE_10
            reset_cause <= CAUSE_POR;
            init_val <= INIT_RST; // RULE_01
            init_load <= LOAD_POR;
        end else if (ce && any_event) begin
            tpd <= next_tpd;
            reset_cause <= next_cause;
            init_val <= INIT_RST; // RULE_09
            init_load <= load_for(next_cause, next_tpd); // RULE_13
        end
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_mask;
    logic [EV_W-1:0] ev_set;

    always_comb begin
        ev_set = '0;
        ev_set[EV_BOR] = bor_rise;
        ev_set[EV_WDT] = watchdog_timeout;
        ev_set[EV_EXT] = ext_rise;
        ev_set[EV_WAKE] = wakeup_event;
        ev_set[EV_RELEASE] = release_evt;
    end

    wire wr_status = reg_wr && (reg_addr == ADDR_IRQ_STATUS);
    wire wr_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
    wire [EV_W-1:0] clr_bits = wr_status ? reg_wdata[EV_W-1:0] : '0;
    // Set wins over a same-cycle clear
    wire [EV_W-1:0] next_irq_status = (irq_status & ~clr_bits) | ev_set;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status <= EV_RESET_VAL;
            irq_mask <= MASK_RESET_VAL;
            irq <= 1'b0;
        end else if (ce) begin
            irq_status <= next_irq_status;
            if (wr_mask) begin
                irq_mask <= reg_wdata[EV_W-1:0];
            end
            irq <= |(next_irq_status & (wr_mask ? reg_wdata[EV_W-1:0] : irq_mask));
        end
    end

    // ************************************************************
    // Register read
    // ************************************************************
    wire [DATA_W-1:0] rd_status = {{(DATA_W-EV_W){1'b0}}, irq_status};
    wire [DATA_W-1:0] rd_mask = {{(DATA_W-EV_W){1'b0}}, irq_mask};
    wire [DATA_W-1:0] rd_cause = {core_reset, 1'b0, tpd, 1'b0, reset_cause};
    wire [DATA_W-1:0] rd_sources = {3'h0, bor_enabled, state, ext_active, bor_active};
    wire [DATA_W-1:0] rd_mux = (reg_addr == ADDR_IRQ_STATUS) ? rd_status :
                               (reg_addr == ADDR_IRQ_MASK) ? rd_mask :
                               (reg_addr == ADDR_CAUSE) ? rd_cause :
                               (reg_addr == ADDR_SOURCES) ? rd_sources : '0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

endmodule // rsq_reset_seq

/* File: rsq_reset_seq_properties.sv */
// Purpose: Port-level properties of the reset sequencer.
// Assumes: Bench keeps reset sources several cycles apart.
// Notes: Bound to every rsq_reset_seq instance.
`timescale 1ns/100ps
module rsq_chk
    import rsq_pkg::*;
#(
    parameter int unsigned DRT_CYCLES = 1024
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Reset sources
    input wire logic ext_reset_pin_n,
    input wire logic brownout_det,
    input wire logic [FUSE_W-1:0] extended_fuse_word,
    input wire logic watchdog_timeout,
    input wire logic wakeup_event,
    input wire logic in_powerdown,
    // Core side
    input wire logic core_reset,
    input wire rsq_init_t init_val,
    input wire rsq_load_t init_load,
    input wire rsq_cause_t reset_cause,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic irq
);
    // ********************************
    // Hold length counter
    // ********************************
    localparam int unsigned HOLD_MAX = (DRT_CYCLES + 1023) / 1024 * 1024 + 24;
    wire bor_en = extended_fuse_word[FUSE_BOR_HI_BIT:FUSE_BOR_LO_BIT] != BOR_CFG_OFF;
    wire restart = watchdog_timeout | wakeup_event | !ext_reset_pin_n | (brownout_det & bor_en);
    logic [31:0] hold_cnt;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) hold_cnt <= '0;
        else if (restart) hold_cnt <= '0;
        else if (core_reset && hold_cnt != '1) hold_cnt <= hold_cnt + 1'b1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_PIN_HOLD: assert property ((!ext_reset_pin_n) [*6] |-> core_reset)
        else $error("pin low without core reset");
    AST_BOR_HOLD: assert property ((brownout_det && bor_en) [*6] |-> core_reset)
        else $error("brown-out without core reset");
    AST_BOR_OFF: assert property (!bor_en && !core_reset && ext_reset_pin_n
        && !watchdog_timeout && !wakeup_event |=> !core_reset)
        else $error("disabled brown-out caused reset");
    AST_WDT_CAUSE: assert property (watchdog_timeout && !brownout_det |=> core_reset
        && reset_cause == CAUSE_WDT
        && init_load.tpd == ($past(in_powerdown) ? TPD_WDT_PD : TPD_WDT_ACT))
        else $error("watchdog cause or flags wrong");
    AST_WAKE_CAUSE: assert property (wakeup_event && !watchdog_timeout && !brownout_det
        && ext_reset_pin_n |=> core_reset && reset_cause == CAUSE_WAKE && $stable(init_load.tpd))
        else $error("wakeup cause or flags wrong");
    AST_PORT_INIT: assert property (core_reset |-> {init_val.option, init_val.port_dir,
        init_val.wake_edge_sel, init_val.wake_enable_n, init_val.input_level_select,
        init_val.schmitt_select, init_val.pullup_enable_n} == {7{ALL_ONES_RST}}
        && init_val.mode == MODE_RST)
        else $error("port init values wrong");
    AST_PC_INIT: assert property (core_reset |-> init_val.pc == PC_TOP
        && init_val.pcl == PCL_RST)
        else $error("program counter init wrong");
    AST_CMP_STAT: assert property (core_reset |-> init_val.comparator_ctrl[7:6] == 2'h3
        && init_val.comparator_ctrl[0] && init_val.status_hi == STATUS_HI_RST)
        else $error("comparator or status init wrong");
    AST_HOLD_MIN: assert property ($fell(core_reset) |-> hold_cnt >= DRT_CYCLES)
        else $error("released before delay");
    AST_HOLD_MAX: assert property (core_reset |-> hold_cnt < HOLD_MAX)
        else $error("reset held too long");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    AST_IRQ_OFF: assert property (reg_wr && reg_addr == ADDR_IRQ_MASK && reg_wdata == 8'h00
        |-> ##2 !irq)
        else $error("irq high with mask clear");
endmodule // rsq_chk
bind rsq_reset_seq rsq_chk #(.DRT_CYCLES(DRT_CYCLES)) u_chk (
    .mclk(mclk), .rst(rst), .ce(ce), .ext_reset_pin_n(ext_reset_pin_n),
    .brownout_det(brownout_det), .extended_fuse_word(extended_fuse_word),
    .watchdog_timeout(watchdog_timeout), .wakeup_event(wakeup_event),
    .in_powerdown(in_powerdown), .core_reset(core_reset), .init_val(init_val),
    .init_load(init_load), .reset_cause(reset_cause), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
);

/* File: rsq_core_model.sv */
// Purpose: Core register image and pulled-up reset pin.
// Assumes: Loads while core reset is high.
// Notes: Undefined bits load as zero.
`timescale 1ns/100ps
module rsq_core_model
    import rsq_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Pin
    input wire logic hold_low,
    output logic ext_reset_pin_n,
    // Core side
    input wire logic core_reset,
    input wire rsq_init_t init_val,
    input wire rsq_load_t init_load,
    output rsq_init_t img,
    output logic [1:0] flags,
    output logic [7:0] fsp
);
    // Pull-up; only ever driven low
    assign ext_reset_pin_n = !hold_low;
    always_ff @(posedge mclk) begin
        if (core_reset && init_load.load_fixed) begin
            img <= init_val;
            flags <= init_load.tpd;
            if (init_load.load_fsp_top) fsp[7] <= FSP_TOP_RST;
            if (init_load.fsp_low_undef) fsp[6:0] <= 7'h00;
        end
    end
endmodule // rsq_core_model

/* File: tb_top.sv */
// Purpose: Self-checking bench of the reset sequencer.
// Assumes: Short delay timer, one tick per cycle.
// Notes: Tasks start on a clock edge.
`timescale 1ns/100ps
module tb_top;
    import rsq_pkg::*;
    localparam int unsigned DRT = 1024;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic pin_low = 1'b1;
    logic brownout_det = 1'b0;
    logic [FUSE_W-1:0] fuse = 12'h000;
    logic wdt = 1'b0;
    logic wake = 1'b0;
    logic pd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire ext_reset_pin_n, core_reset, irq;
    wire [DATA_W-1:0] reg_rdata;
    wire rsq_init_t init_val, img;
    wire rsq_load_t init_load;
    wire rsq_cause_t reset_cause;
    wire [1:0] flags;
    wire [7:0] fsp;
    int bad_count = 0;
    int n_compared = 0;
    int cyc_cnt = 0;
    always #2.5 mclk = ~mclk;
    rsq_reset_seq #(.DRT_CYCLES(DRT)) DUT (
        .mclk(mclk), .rst(rst), .ce(ce), .ext_reset_pin_n(ext_reset_pin_n),
        .brownout_det(brownout_det), .extended_fuse_word(fuse), .watchdog_timeout(wdt),
        .wakeup_event(wake), .in_powerdown(pd), .core_reset(core_reset), .init_val(init_val),
        .init_load(init_load), .reset_cause(reset_cause), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
    );
    rsq_core_model u_core (
        .mclk(mclk), .hold_low(pin_low), .ext_reset_pin_n(ext_reset_pin_n),
        .core_reset(core_reset), .init_val(init_val), .init_load(init_load),
        .img(img), .flags(flags), .fsp(fsp)
    );
    // ********************************
    // Shared tasks
    // ********************************
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic c, input string m);
        n_compared++;
        if (c !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string m);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata === e, m);
    endtask
    task automatic rel(input string m);
        int n;
        n = 0;
        while (core_reset !== 1'b0 && n < 1200) begin
            @(posedge mclk);
            #1 n++;
        end
        chk(n >= DRT && n < 1200, m);
    endtask
    task automatic pulse(input logic w, input logic p);
        @(posedge mclk);
        pd <= p;
        wdt <= w;
        wake <= !w;
        @(posedge mclk);
        wdt <= 1'b0;
        wake <= 1'b0;
        #1;
    endtask
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_por();
        #1 chk(core_reset === 1'b1 && reset_cause === CAUSE_POR, "por");
        chk(init_load.tpd === TPD_POWERUP && !init_load.load_fsp_top, "por load");
        chk(init_load.volatile_undef === 1'b1, "por undef");
        rd(ADDR_IRQ_STATUS, 8'h01, "status");
        rd(ADDR_IRQ_MASK, 8'h00, "mask");
        rd(4'h9, 8'h00, "unmapped");
        rd(ADDR_SOURCES, 8'h12, "hold");
        cyc(1200);
        chk(core_reset === 1'b1, "pin hold");
        pin_low <= 1'b0;
        rel("por rel");
        rd(ADDR_SOURCES, 8'h1c, "run");
        rd(ADDR_IRQ_STATUS, 8'h21, "release");
    endtask
    task automatic t_wdt(input logic p);
        pulse(1'b1, p);
        chk(core_reset === 1'b1 && reset_cause === CAUSE_WDT, "wdt");
        chk(init_load.tpd === (p ? TPD_WDT_PD : TPD_WDT_ACT), "wdt tpd");
        chk(init_load.load_fsp_top && !init_load.volatile_undef, "wdt keep");
        cyc(500);
        pulse(1'b1, p);
        rel("wdt restart");
        chk(flags === (p ? TPD_WDT_PD : TPD_WDT_ACT) && fsp[7] === 1'b1, "img");
        rd(ADDR_CAUSE, {2'h0, p ? TPD_WDT_PD : TPD_WDT_ACT, 1'b0, CAUSE_WDT}, "cause");
    endtask
    task automatic t_ext(input logic p, input logic [1:0] e);
        @(posedge mclk);
        pd <= p;
        pin_low <= 1'b1;
        cyc(8);
        #1 chk(core_reset === 1'b1 && reset_cause === CAUSE_EXT, "ext");
        chk(init_load.tpd === e && !init_load.volatile_undef, "ext tpd");
        cyc(50);
        pin_low <= 1'b0;
        pd <= 1'b0;
        rel("ext rel");
    endtask
    task automatic t_wake();
        pulse(1'b0, 1'b1);
        chk(core_reset === 1'b1 && reset_cause === CAUSE_WAKE, "wake");
        chk(init_load.tpd === TPD_EXT_PD && init_val.pcl === PCL_RST, "wake load");
        rel("wake rel");
        chk(img.pc === PC_TOP && img.status_hi === STATUS_HI_RST, "wake img");
    endtask
    task automatic t_bor();
        @(posedge mclk);
        pd <= 1'b0;
        brownout_det <= 1'b1;
        cyc(6);
        #1 chk(core_reset === 1'b1 && reset_cause === CAUSE_BOR, "bor");
        chk(init_load.fsp_low_undef && init_load.volatile_undef, "bor undef");
        cyc(1200);
        chk(core_reset === 1'b1, "bor hold");
        brownout_det <= 1'b0;
        rel("bor rel");
        chk(fsp === 8'h80 && img.option === ALL_ONES_RST && img.mode === MODE_RST, "img");
        chk(img.comparator_ctrl[7:6] === 2'h3 && img.comparator_ctrl[0] === 1'b1, "cmp");
        @(posedge mclk);
        fuse <= 12'h0c0;
        brownout_det <= 1'b1;
        cyc(50);
        #1 chk(core_reset === 1'b0, "bor off");
        @(posedge mclk);
        brownout_det <= 1'b0;
        cyc(4);
        fuse <= 12'h000;
    endtask
    task automatic t_irq();
        rd(ADDR_IRQ_STATUS, 8'h3f, "events");
        chk(irq === 1'b0, "masked");
        wr(ADDR_IRQ_MASK, 8'h04);
        cyc(2);
        #1 chk(irq === 1'b1, "irq on");
        wr(ADDR_IRQ_STATUS, 8'h04);
        cyc(2);
        #1 chk(irq === 1'b0, "irq cleared");
        rd(ADDR_IRQ_STATUS, 8'h3b, "w1c");
        wr(ADDR_IRQ_MASK, 8'h3f);
        cyc(2);
        #1 chk(irq === 1'b1, "irq all");
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_CAUSE, 8'hff);
        rd(ADDR_CAUSE, {2'h0, TPD_EXT_PD, 1'b0, CAUSE_BOR}, "cause ro");
        wr(ADDR_IRQ_STATUS, 8'h3f);
        rd(ADDR_IRQ_STATUS, 8'h00, "clear all");
    endtask
    initial begin
        cyc(20);
        rst <= 1'b0;
        @(posedge mclk);
        t_por();
        t_wdt(1'b1);
        t_wdt(1'b0);
        t_ext(1'b0, TPD_WDT_ACT);
        t_ext(1'b1, TPD_EXT_PD);
        t_wake();
        t_bor();
        t_irq();
        close_out();
    end
endmodule // tb_top
